// File: pea_top.sv
// Top: two-wire slave for clock/SRAM space and protected 8-byte block
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Up to eight buffered bytes, written after Stop
// - Each block data byte steps only low three bits
// - Ninth byte wraps and overwrites buffered byte
// - Stop after unlocked block data write starts timed cycle
// - Block control bytes unacknowledged while cycle runs
// - Polling may start right after Stop
// - Cycle done: polling control byte acknowledged
// - Read control acked, returns byte at pointer
// - Host no-ack then Stop ends driving
// - One pointer shared by both spaces
// - Word address loads pointer before repeated Start
// - After read, pointer follows last byte
// - Host ack sends next byte, advances pointer
// - Pointer wraps from last to first location
// - Node address preloaded in upper six bytes
// - Key 0x55 then 0xAA unlocks one write
// - Block addresses outside page are refused
// - Block relocked by Stop after an accepted block word address
// - Clock and SRAM served during cycle
module pea_top #(
    parameter int WR_CYCLES = pea_pkg::WR_CYC // Write cycle, clk cycles
) (
    input wire logic clk, // Core clock, 10 MHz
    input wire logic rst, // Async reset, active high
    input wire logic link_clk, // Bus sampling clock
    input wire logic scl_i, // Bus clock level
    input wire logic sda_i, // Bus data level
    output logic sda_o, // Level driven on data
    output logic sda_oe, // High while pulling data low
    output logic nv_busy // Internal write cycle pending
);
    import pea_pkg::*;

    // ----------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------
    pea_state_e st_reg;
    pea_phase_e ph_reg;
    logic [1:0] pin_s;
    logic scl_s;
    logic sda_s;
    logic scl_d_reg;
    logic sda_d_reg;
    logic [3:0] cnt_reg;
    logic [7:0] sh_reg;
    logic [7:0] ptr_reg;
    logic sel_ee_reg;
    logic rw_reg;
    logic key_st_reg;
    logic unlock_reg;
    logic busy_reg;
    logic req_reg;
    logic ack_s;
    logic ack_d_reg;
    logic [63:0] page_reg;
    logic [7:0] mask_reg;
    logic [7:0] mem_reg [MEM_WORDS];
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic byte_end;
    logic sel_now;
    logic ack_now;
    logic take_ctrl;
    logic take_word;
    logic take_data;
    logic rack_more;
    logic tx_load;
    logic ee_wr_cmd;
    logic commit;
    logic [7:0] rd_byte;

    pea_nv_if nvi ();

    // ----------------------------------------------------------
    // Pin sampling and bus conditions
    // ----------------------------------------------------------
    pea_sync #(.W(2)) u_pin (
        .clk(link_clk),
        .rst(rst),
        .d({scl_i, sda_i}),
        .q(pin_s)
    );
    assign scl_s = pin_s[1];
    assign sda_s = pin_s[0];

    // Previous sampled levels
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            scl_d_reg <= 1'b0;
            sda_d_reg <= 1'b0;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    // Edges, Start and Stop
    assign scl_rise = scl_s && !scl_d_reg;
    assign scl_fall = !scl_s && scl_d_reg;
    assign start_c = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    assign stop_c = scl_s && scl_d_reg && !sda_d_reg && sda_s;

    // ----------------------------------------------------------
    // Byte decisions
    // ----------------------------------------------------------
    assign byte_end = (st_reg == S_RX) && scl_fall && (cnt_reg == BIT_LAST);
    assign sel_now = (ph_reg == PH_CTRL) ? (sh_reg[7:1] == EE_DEV)
        : sel_ee_reg;
    assign take_ctrl = byte_end && (ph_reg == PH_CTRL) && ack_now;
    assign take_word = byte_end && (ph_reg == PH_WORD) && ack_now;
    assign take_data = byte_end && (ph_reg == PH_DATA);
    assign rack_more = (st_reg == S_RACK) && scl_rise && !sda_s;
    assign tx_load = (take_ctrl && sh_reg[0]) || rack_more;
    assign ee_wr_cmd = sel_ee_reg && !rw_reg && (ph_reg == PH_DATA);
    assign commit = stop_c && ee_wr_cmd && unlock_reg && (mask_reg != '0);

    // Acknowledge decision for the byte just received
    always_comb begin
        ack_now = 1'b0;
        unique case (ph_reg)
            PH_CTRL: ack_now = ((sh_reg[7:1] == EE_DEV) && !busy_reg)
                || (sh_reg[7:1] == RTC_DEV);
            PH_WORD: ack_now = sel_ee_reg ? (sh_reg[7:3] == EE_PAGE)
                : (sh_reg <= SRAM_LAST);
            PH_DATA: ack_now = 1'b1;
            default: ack_now = 1'b0;
        endcase
    end

    // Byte at the pointer; key location reads as zero
    always_comb begin
        rd_byte = 8'h00;
        if (sel_now) begin
            if (ptr_reg[7:3] == EE_PAGE)
                rd_byte = nvi.ee_data[{ptr_reg[2:0], 3'h0} +: 8];
        end else if (ptr_reg <= SRAM_LAST && ptr_reg != KEY_LOC) begin
            rd_byte = mem_reg[ptr_reg[6:0]];
        end
    end

    // Pointer step with per-space rollover
    function automatic logic [7:0] nxt(input logic [7:0] a);
        if (a[7:3] == EE_PAGE)
            return {EE_PAGE, a[2:0] + 3'h1};
        else if (a == RTC_LAST)
            return RTC_FIRST;
        else if (a == SRAM_LAST)
            return SRAM_FIRST;
        else
            return a + 8'h01;
    endfunction

    // ----------------------------------------------------------
    // Bus state machine
    // ----------------------------------------------------------
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            st_reg <= S_IDLE;
            ph_reg <= PH_CTRL;
            cnt_reg <= '0;
            sh_reg <= '0;
            sda_o <= 1'b0;
            sda_oe <= 1'b0;
            sel_ee_reg <= 1'b0;
            rw_reg <= 1'b0;
        end else if (start_c) begin
            st_reg <= S_RX;
            ph_reg <= PH_CTRL;
            cnt_reg <= '0;
            sda_oe <= 1'b0;
        end else if (stop_c) begin
            st_reg <= S_IDLE;
            ph_reg <= PH_CTRL;
            sda_oe <= 1'b0;
        end else begin
            unique case (st_reg)
                S_IDLE: cnt_reg <= '0;
                S_RX: begin
                    if (scl_rise && cnt_reg != BIT_LAST) begin
                        sh_reg <= {sh_reg[6:0], sda_s};
                        cnt_reg <= cnt_reg + 4'h1;
                    end else if (byte_end) begin
                        cnt_reg <= '0;
                        if (!ack_now) begin
                            st_reg <= S_IDLE;
                        end else begin
                            st_reg <= S_ACK;
                            sda_o <= 1'b0;
                            sda_oe <= 1'b1;
                            if (ph_reg == PH_CTRL) begin
                                sel_ee_reg <= sel_now;
                                rw_reg <= sh_reg[0];
                                ph_reg <= sh_reg[0] ? PH_DATA : PH_WORD;
                                if (sh_reg[0])
                                    sh_reg <= rd_byte;
                            end else begin
                                ph_reg <= PH_DATA;
                            end
                        end
                    end
                end
                S_ACK: begin
                    if (scl_fall && rw_reg) begin
                        st_reg <= S_TX;
                        sda_o <= sh_reg[7];
                        sda_oe <= !sh_reg[7];
                        sh_reg <= {sh_reg[6:0], 1'b0};
                        cnt_reg <= 4'h1;
                    end else if (scl_fall) begin
                        st_reg <= S_RX;
                        sda_oe <= 1'b0;
                    end
                end
                S_TX: begin
                    if (scl_fall && cnt_reg == BIT_LAST) begin
                        st_reg <= S_RACK;
                        sda_oe <= 1'b0;
                    end else if (scl_fall) begin
                        sda_o <= sh_reg[7];
                        sda_oe <= !sh_reg[7];
                        sh_reg <= {sh_reg[6:0], 1'b0};
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                S_RACK: begin
                    if (rack_more) begin
                        st_reg <= S_TX;
                        cnt_reg <= '0;
                        sh_reg <= rd_byte;
                    end else if (scl_rise) begin
                        st_reg <= S_IDLE;
                    end
                end
                default: st_reg <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------
    // Shared pointer, memories and key
    // ----------------------------------------------------------
    // One pointer for both spaces
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            ptr_reg <= RTC_FIRST;
        end else if (take_word) begin
            ptr_reg <= sh_reg;
        end else if (tx_load) begin
            ptr_reg <= nxt(ptr_reg);
        end else if (take_data && sel_ee_reg) begin
            ptr_reg <= {ptr_reg[7:3], ptr_reg[2:0] + 3'h1};
        end else if (take_data) begin
            ptr_reg <= nxt(ptr_reg);
        end
    end

    // Clock registers and SRAM, served in any cycle
    always_ff @(posedge link_clk) begin
        if (take_data && !sel_ee_reg && ptr_reg <= SRAM_LAST
            && ptr_reg != KEY_LOC)
            mem_reg[ptr_reg[6:0]] <= sh_reg;
    end

    // Unlock sequence and relock
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            key_st_reg <= 1'b0;
            unlock_reg <= 1'b0;
        end else if (stop_c && ee_wr_cmd) begin
            key_st_reg <= 1'b0;
            unlock_reg <= 1'b0;
        end else if (take_data && !sel_ee_reg) begin
            if (ptr_reg == KEY_LOC && sh_reg == KEY_ONE) begin
                key_st_reg <= 1'b1;
                unlock_reg <= 1'b0;
            end else if (ptr_reg == KEY_LOC && sh_reg == KEY_TWO) begin
                key_st_reg <= 1'b0;
                unlock_reg <= key_st_reg;
            end else begin
                key_st_reg <= 1'b0;
                unlock_reg <= 1'b0;
            end
        end
    end

    // Page buffer, wraps within eight bytes
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            page_reg <= '0;
            mask_reg <= '0;
        end else if (take_ctrl && sel_now && !sh_reg[0]) begin
            mask_reg <= '0;
        end else if (take_data && sel_ee_reg && unlock_reg) begin
            page_reg[{ptr_reg[2:0], 3'h0} +: 8] <= sh_reg;
            mask_reg[ptr_reg[2:0]] <= 1'b1;
        end
    end

    // ----------------------------------------------------------
    // Commit handshake to the core domain
    // ----------------------------------------------------------
    pea_sync #(.W(1)) u_ack (
        .clk(link_clk),
        .rst(rst),
        .d(nvi.ack_tgl),
        .q(ack_s)
    );

    // Busy from Stop until completion returns
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            busy_reg <= 1'b0;
            req_reg <= 1'b0;
            ack_d_reg <= 1'b0;
        end else begin
            ack_d_reg <= ack_s;
            if (commit) begin
                busy_reg <= 1'b1;
                req_reg <= ~req_reg;
            end else if (ack_s != ack_d_reg) begin
                busy_reg <= 1'b0;
            end
        end
    end

    assign nvi.req_tgl = req_reg;
    assign nvi.page = page_reg;
    assign nvi.mask = mask_reg;
    assign nv_busy = busy_reg;

    pea_nv #(.WR_CYCLES(WR_CYCLES)) u_nv (
        .clk(clk),
        .rst(rst),
        .nv(nvi.nv)
    );

    // ----------------------------------------------------------
    // Checks
    // ----------------------------------------------------------
    default clocking cb_link @(posedge link_clk);
    endclocking
    default disable iff (rst);

    sequence s_ee_ctrl_busy;
        byte_end && ph_reg == PH_CTRL && sh_reg[7:1] == EE_DEV && busy_reg;
    endsequence
    sequence s_rtc_ctrl;
        byte_end && ph_reg == PH_CTRL && sh_reg[7:1] == RTC_DEV;
    endsequence
    sequence s_key_two;
        take_data && !sel_ee_reg && ptr_reg == KEY_LOC
            && sh_reg == KEY_TWO && key_st_reg;
    endsequence

    AST_BUSY_NACK: assert property (
        s_ee_ctrl_busy |=> st_reg == S_IDLE && !sda_oe)
        else $error("block control byte acked while busy");

    AST_CLOCK_ACK: assert property (
        s_rtc_ctrl |=> st_reg == S_ACK && sda_oe)
        else $error("clock space control byte not acked");

    AST_COMMIT: assert property (
        stop_c && ee_wr_cmd && unlock_reg && mask_reg != '0
        |=> busy_reg && req_reg != $past(req_reg))
        else $error("stop did not start write cycle");

    AST_RELOCK: assert property (
        stop_c && ee_wr_cmd |=> !unlock_reg ##1 !unlock_reg)
        else $error("block not relocked after write");

    AST_PAGE_STEP: assert property (
        take_data && sel_ee_reg |=> ptr_reg[7:3] == $past(ptr_reg[7:3])
        && ptr_reg[2:0] == $past(ptr_reg[2:0]) + 3'h1)
        else $error("page pointer step wrong");

    AST_EE_WRAP: assert property (
        tx_load && sel_now && ptr_reg == EE_LAST |=> ptr_reg == EE_FIRST)
        else $error("block pointer did not wrap");

    AST_WORD_REFUSE: assert property (
        byte_end && ph_reg == PH_WORD && sel_ee_reg && sh_reg[7:3] != EE_PAGE
        |=> st_reg == S_IDLE && !sda_oe)
        else $error("address outside block acked");

    AST_STOP_RELEASE: assert property (
        stop_c |=> !sda_oe && st_reg == S_IDLE)
        else $error("data still driven after stop");

    AST_UNLOCK: assert property (
        s_key_two |=> unlock_reg)
        else $error("key sequence did not unlock");
endmodule
`default_nettype wire

// File: pea_pkg.sv
// Constants and types for the protected nonvolatile block access logic
package pea_pkg;
    // Core clock and internal write cycle
    localparam int CLK_MHZ = 10;
    localparam int WR_TIME_US = 5000;
    localparam int WR_CYC = WR_TIME_US * CLK_MHZ;
    // Bus device addresses, 7-bit
    localparam logic [6:0] EE_DEV = 7'h57;
    localparam logic [6:0] RTC_DEV = 7'h6f;
    // Address map
    localparam logic [4:0] EE_PAGE = 5'h1e;
    localparam logic [7:0] EE_FIRST = 8'hf0;
    localparam logic [7:0] EE_LAST = 8'hf7;
    localparam logic [7:0] RTC_FIRST = 8'h00;
    localparam logic [7:0] RTC_LAST = 8'h1f;
    localparam logic [7:0] SRAM_FIRST = 8'h20;
    localparam logic [7:0] SRAM_LAST = 8'h5f;
    localparam int MEM_WORDS = 96;
    localparam int PAGE_BYTES = 8;
    // Write key location and its sequence
    localparam logic [7:0] KEY_LOC = 8'h09;
    localparam logic [7:0] KEY_ONE = 8'h55;
    localparam logic [7:0] KEY_TWO = 8'haa;
    // Serial byte framing
    localparam logic [3:0] BIT_LAST = 4'h8;
    // Factory content; node address value is arbitrary
    localparam logic NODE_PRELOAD = 1'b1;
    localparam int NODE_AT = 2;
    localparam logic [47:0] NODE_ADDR = 48'h02_11_22_33_44_55;
    localparam logic [7:0] BLANK_BYTE = 8'hff;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_RX = 5'b00010,
        S_ACK = 5'b00100,
        S_TX = 5'b01000,
        S_RACK = 5'b10000
    } pea_state_e;

    typedef enum logic [2:0] {
        PH_CTRL = 3'b001,
        PH_WORD = 3'b010,
        PH_DATA = 3'b100
    } pea_phase_e;
endpackage

// File: pea_nv_if.sv
// Interface: commit handshake and array contents between the two domains
`timescale 1ns/1ps
`default_nettype none
interface pea_nv_if;
    logic req_tgl;
    logic ack_tgl;
    logic [63:0] page;
    logic [7:0] mask;
    logic [63:0] ee_data;
    modport link (output req_tgl, page, mask, input ack_tgl, ee_data);
    modport nv (input req_tgl, page, mask, output ack_tgl, ee_data);
endinterface
`default_nettype wire

// File: pea_sync.sv
// Two flip-flop synchroniser for levels
`timescale 1ns/1ps
`default_nettype none
module pea_sync #(
    parameter int W = 1 // Number of levels
) (
    input wire logic clk, // Destination clock
    input wire logic rst, // Async reset, active high
    input wire logic [W-1:0] d, // Foreign levels
    output logic [W-1:0] q // Levels in clk domain
);
    import pea_pkg::*;
    logic [W-1:0] meta_reg;

    // Two stages, first read only by second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// File: pea_nv.sv
// Nonvolatile array with its self-timed write cycle, core clock domain
`timescale 1ns/1ps
`default_nettype none
module pea_nv #(
    parameter int WR_CYCLES = pea_pkg::WR_CYC // Write cycle length
) (
    input wire logic clk, // Core clock
    input wire logic rst, // Async reset, active high
    pea_nv_if.nv nv // Commit handshake and contents
);
    import pea_pkg::*;
    logic req_s;
    logic req_d_reg;
    logic req_edge;
    logic busy_reg;
    logic ack_reg;
    logic done;
    logic [31:0] cnt_reg;
    logic [7:0] ee_reg [PAGE_BYTES];

    pea_sync #(.W(1)) u_req (
        .clk(clk),
        .rst(rst),
        .d(nv.req_tgl),
        .q(req_s)
    );

    assign req_edge = req_s ^ req_d_reg;
    assign done = busy_reg && (cnt_reg == 32'(WR_CYCLES - 1));

    // Write cycle timer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_d_reg <= 1'b0;
            busy_reg <= 1'b0;
            cnt_reg <= '0;
        end else begin
            req_d_reg <= req_s;
            if (req_edge) begin
                busy_reg <= 1'b1;
                cnt_reg <= '0;
            end else if (done) begin
                busy_reg <= 1'b0;
            end else if (busy_reg) begin
                cnt_reg <= cnt_reg + 32'h1;
            end
        end
    end

    // Completion toggles back to the link side
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
        end else if (done) begin
            ack_reg <= ~ack_reg;
        end
    end

    // Array: factory content, updated at end of cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (NODE_PRELOAD && i >= NODE_AT)
                    ee_reg[i] <= NODE_ADDR[(PAGE_BYTES-1-i)*8 +: 8];
                else
                    ee_reg[i] <= BLANK_BYTE;
            end
        end else if (done) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (nv.mask[i])
                    ee_reg[i] <= nv.page[i*8 +: 8];
            end
        end
    end

    // Contents out, stable while no cycle runs
    always_comb begin
        for (int i = 0; i < PAGE_BYTES; i++)
            nv.ee_data[i*8 +: 8] = ee_reg[i];
    end
    assign nv.ack_tgl = ack_reg;

    AST_CYCLE_START: assert property (@(posedge clk) disable iff (rst)
        req_edge |=> busy_reg && cnt_reg == 32'h0)
        else $error("write cycle did not start on request");

    AST_CYCLE_END: assert property (@(posedge clk) disable iff (rst)
        done |=> !busy_reg && ack_reg != $past(ack_reg))
        else $error("write cycle end not signalled");
endmodule
`default_nettype wire

// File: pea_host.sv
// Two-wire bus host model at the block's far side
`timescale 1ns/1ps
`default_nettype none
module pea_host (
    input wire logic clk, // Pacing clock, one bus phase each
    input wire logic sda_w, // Resolved data wire
    output logic scl, // Bus clock
    output logic sda // Host data drive, 1 releases
);
    // Bus idles high
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // One phase; callers change only one line at a time
    task automatic ph(input logic c, input logic d);
        @(posedge clk);
        #1;
        scl = c;
        sda = d;
    endtask
    // Bit slot: data set while low, sampled mid-high, one pacing clock before clock falls
    task automatic bit_x(input logic d, output logic q);
        ph(1'b0, d);
        ph(1'b1, d);
        @(posedge clk);
        q = sda_w;
        ph(1'b0, d);
    endtask
    // Start, also repeated Start from a low clock
    task automatic start();
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
        ph(1'b0, 1'b0);
    endtask
    // Stop leaves the bus idle
    task automatic stop();
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
    endtask
    // Byte out MSB first; ack means device pulled low
    task automatic wbyte(input logic [7:0] v, output logic ack);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            bit_x(v[i], q);
        end
        bit_x(1'b1, q);
        ack = ~q;
    endtask
    // Byte in; more high acknowledges for another byte
    task automatic rbyte(input logic more, output logic [7:0] v);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, v[i]);
        end
        bit_x(~more, q);
    endtask
endmodule
`default_nettype wire

// File: tb_protected_eeprom_i2c_access.sv
// Self-checking bench for the protected block access logic
`timescale 1ns/1ps
`default_nettype none
module tb_protected_eeprom_i2c_access;
    import pea_pkg::*;
    logic clk, rst, link_clk, sda_o, sda_oe, nv_busy, scl, sda, ack;
    logic [7:0] b;
    int fails = 0;
    int checks_done = 0;
    // Open-drain data wire with pull-up
    wire logic sda_w = sda & (~sda_oe | sda_o);
    pea_top #(.WR_CYCLES(200)) uut (.clk(clk), .rst(rst),
        .link_clk(link_clk), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe(sda_oe), .nv_busy(nv_busy));
    pea_host host (.clk(clk), .sda_w(sda_w), .scl(scl), .sda(sda));
    // Core and link clocks, unrelated phases
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #3;
        forever #6 link_clk = ~link_clk;
    end
    // ---------------------------------------------
    // Helpers
    // ---------------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic [7:0] v, input logic e);
        host.wbyte(v, ack);
        chk({7'h00, ack}, {7'h00, e});
    endtask
    task automatic rb(input logic more, input logic [7:0] e);
        host.rbyte(more, b);
        chk(b, e);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Write while locked is taken but dropped
    task automatic t_lock;
        host.start();
        wb(8'hae, 1'b1);
        wb(EE_FIRST, 1'b1);
        wb(8'h12, 1'b1);
        host.stop();
        $display("t_lock done");
    endtask
    // Random then sequential read over the wrap
    task automatic t_read;
        host.start();
        wb(8'hae, 1'b1);
        wb(8'hf2, 1'b1);
        host.start();
        wb(8'haf, 1'b1);
        for (int i = 0; i < 7; i++) begin
            rb(i < 6, i < 6 ? NODE_ADDR[47-8*i -: 8] : BLANK_BYTE);
        end
        host.stop();
        $display("t_read done");
    endtask
    // Unlock, nine-byte page write, polling, readback
    task automatic t_page;
        for (int k = 0; k < 2; k++) begin
            host.start();
            wb(8'hde, 1'b1);
            wb(KEY_LOC, 1'b1);
            wb(k == 0 ? KEY_ONE : KEY_TWO, 1'b1);
            host.stop();
        end
        host.start();
        wb(8'hae, 1'b1);
        wb(8'hf6, 1'b1);
        for (int i = 0; i < 9; i++) begin
            wb(8'(8'h80 + i), 1'b1);
        end
        host.stop();
        repeat (3) @(posedge clk);
        chk({7'h00, nv_busy}, 8'h01);
        host.start();
        wb(8'hae, 1'b0);
        host.start();
        wb(8'hde, 1'b1);
        host.stop();
        ack = 1'b0;
        for (int n = 0; n < 40 && ack !== 1'b1; n++) begin
            host.start();
            host.wbyte(8'hae, ack);
        end
        chk({7'h00, ack}, 8'h01);
        wb(EE_FIRST, 1'b1);
        host.start();
        wb(8'haf, 1'b1);
        for (int k = 0; k < 8; k++) begin
            rb(k < 7, k == 6 ? 8'h88 : 8'(8'h80 + (k + 2) % 8));
        end
        host.stop();
        host.start();
        wb(8'haf, 1'b1);
        rb(1'b0, 8'h82);
        host.stop();
        host.start();
        wb(8'hae, 1'b1);
        wb(EE_FIRST, 1'b1);
        wb(8'h00, 1'b1);
        host.stop();
        repeat (5) @(posedge clk);
        chk({7'h00, nv_busy}, 8'h00);
        host.start();
        wb(8'hae, 1'b1);
        wb(EE_FIRST, 1'b1);
        host.start();
        wb(8'haf, 1'b1);
        rb(1'b0, 8'h82);
        host.stop();
        $display("t_page done");
    endtask
    // Out-of-page address refused; pointer shared
    task automatic t_range;
        host.start();
        wb(8'hae, 1'b1);
        wb(8'he0, 1'b0);
        host.stop();
        host.start();
        wb(8'hde, 1'b1);
        wb(SRAM_FIRST, 1'b1);
        host.stop();
        host.start();
        wb(8'haf, 1'b1);
        rb(1'b0, 8'h00);
        host.stop();
        $display("t_range done");
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        repeat (2) @(posedge clk);
        t_lock();
        t_read();
        t_page();
        t_range();
        end_of_test();
    end
    // Watchdog against a hung bus
    initial begin
        #2000000;
        fails++;
        end_of_test();
    end
endmodule
`default_nettype wire
